// file: eid_decoder.sv
// extended instruction decode and execute sequencer
`include "eid_defs.svh"
`default_nettype none
module eid_decoder (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ext_set_enable_cfg,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [11:0] file_select_pointer0,
  input wire logic [11:0] file_select_pointer1,
  input wire logic [11:0] pointer_reg_2,
  input wire logic [7:0] working_reg,
  input wire logic [7:0] mem_rdata,
  input wire logic std_access_bit,
  input wire logic [7:0] std_file_operand,
  output logic ext_hit,
  output logic stall,
  output logic idx_mode,
  output logic [11:0] idx_addr,
  output var eid_pkg::eid_ctl_s ctl,
  output var eid_pkg::eid_op_e op_seen
);
  import eid_pkg::*;

  function automatic logic [11:0] ptr_pick(input logic [1:0] s,
      input logic [11:0] p0, input logic [11:0] p1, input logic [11:0] p2);
    ptr_pick = (s == 2'h0) ? p0 : (s == 2'h1) ? p1 : p2;
  endfunction : ptr_pick

  function automatic logic [11:0] off2(input logic [11:0] p2,
      input logic [6:0] z);
    off2 = p2 + {5'h00, z};
  endfunction : off2

  // enable caught on a clock, never straight from the strap into reset
  logic en_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) en_q <= 1'b0;
    else en_q <= ext_set_enable_cfg;
  end

  eid_state_e state_q, state_d;
  eid_op_e op_q, op_d;
  logic [15:0] first_q;
  logic [7:0] data_q;

  wire [7:0] hi = instr_word[15:8];
  wire [1:0] fsel = instr_word[7:6];
  wire [5:0] lit6 = instr_word[5:0];
  wire is_add = hi == `EID_OP_ADDPTR;
  wire is_sub = hi == `EID_OP_SUBPTR;
  wire is_ret = fsel == `EID_RET_SEL;
  wire take = instr_valid && en_q && state_q == EID_IDLE;
  // return variants always write pointer 2, never select code 3
  wire [1:0] wsel = is_ret ? `EID_PTR2_SEL : fsel;

  // decode of the eight extra encodings
  eid_op_e dec;
  always_comb begin
    dec = EID_NONE;
    if (is_add) dec = is_ret ? EID_ADDR2 : EID_ADDP;
    else if (is_sub) dec = is_ret ? EID_SUBR2 : EID_SUBP;
    else if (hi == `EID_OP_PUSH) dec = EID_PUSH_LIT;
    else if (hi == `EID_OP_MOVS)
      dec = instr_word[7] ? EID_MOVE_II : EID_MOVE_IF;
    else if (instr_word == `EID_CALL_REG_WORD)
      dec = EID_CALL_REG;
  end

  wire hit_now = take && dec != EID_NONE;
  wire second_ok = instr_word[15:12] == `EID_OP_SECOND;
  wire in2 = state_q == EID_SECOND && instr_valid && second_ok;

  // indexed literal offset for standard byte/bit ops
  // second move word is no standard op, so it is kept out too
  assign idx_mode = en_q && !std_access_bit &&
      std_file_operand <= `EID_IDX_LIMIT && !hit_now && !in2;
  assign idx_addr = off2(pointer_reg_2, std_file_operand[6:0]);

  always_comb begin
    state_d = state_q;
    op_d = op_q;
    case (state_q)
      EID_IDLE: begin
        if (hit_now) begin
          op_d = dec;
          case (dec)
            EID_ADDR2, EID_SUBR2: state_d = EID_RETURN;
            EID_CALL_REG: state_d = EID_RETURN;
            EID_MOVE_IF, EID_MOVE_II: state_d = EID_SECOND;
            default: state_d = EID_IDLE;
          endcase
        end
      end
      // stays waiting until the second word really arrives
      EID_SECOND: if (instr_valid && second_ok) state_d = EID_IDLE;
      EID_RETURN: state_d = EID_IDLE;
      default: state_d = EID_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= EID_IDLE;
      op_q <= EID_NONE;
      first_q <= 16'h0000;
      data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      if (hit_now) first_q <= instr_word;
      if (state_q == EID_IDLE) data_q <= mem_rdata;
    end
  end

  // datapath strobes
  wire [11:0] psel = ptr_pick(fsel, file_select_pointer0,
      file_select_pointer1, pointer_reg_2);
  wire [11:0] p2 = pointer_reg_2;
  wire [11:0] src = off2(p2, first_q[6:0]);
  wire [11:0] dst = first_q[7] ? off2(p2, instr_word[6:0])
      : instr_word[11:0];

  always_comb begin
    ctl = '0;
    ctl.status_we = 1'b0;
    if (hit_now) begin
      case (dec)
        EID_ADDP, EID_ADDR2: begin
          ctl.ptr_we = 1'b1;
          ctl.ptr_sel = wsel;
          ctl.ptr_val = psel + {6'h00, lit6};
        end
        EID_SUBP, EID_SUBR2: begin
          ctl.ptr_we = 1'b1;
          ctl.ptr_sel = wsel;
          ctl.ptr_val = psel - {6'h00, lit6};
        end
        EID_PUSH_LIT: begin
          ctl.mem_we = 1'b1;
          ctl.mem_waddr = p2;
          ctl.mem_wdata = instr_word[7:0];
          ctl.ptr_we = 1'b1;
          ctl.ptr_sel = `EID_PTR2_SEL;
          ctl.ptr_val = p2 - 12'h001;
        end
        EID_MOVE_IF, EID_MOVE_II: begin
          ctl.mem_re = 1'b1;
          ctl.mem_raddr = off2(p2, instr_word[6:0]);
        end
        EID_CALL_REG: ctl.do_call_w = 1'b1;
        default: ctl.ptr_we = 1'b0;
      endcase
    end else if (state_q == EID_RETURN) begin
      // return only after the pointer 2 update has landed
      ctl.do_return = op_q == EID_ADDR2 || op_q == EID_SUBR2;
    end else if (in2) begin
      ctl.mem_we = 1'b1;
      ctl.mem_waddr = dst;
      ctl.mem_wdata = data_q;
      ctl.mem_raddr = src;
    end
  end

  assign ext_hit = hit_now || in2;
  assign stall = state_q != EID_IDLE && !in2;
  assign op_seen = op_q;
  // working_reg carried by the core as call target
  wire unused_w = ^working_reg;
endmodule : eid_decoder
`default_nettype wire

// file: eid_decoder_props.sv
// assertion checker for the extended instruction decoder
`default_nettype none
module eid_decoder_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ext_set_enable_cfg,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [11:0] file_select_pointer0,
  input wire logic [11:0] pointer_reg_2,
  input wire logic std_access_bit,
  input wire logic [7:0] std_file_operand,
  input wire logic ext_hit,
  input wire logic stall,
  input wire logic idx_mode,
  input wire logic [11:0] idx_addr,
  input wire eid_pkg::eid_ctl_s ctl
);
  wire logic go = instr_valid && ext_hit && !stall;
  wire logic [7:0] op = instr_word[15:8];
  wire logic [11:0] k = {6'h00, instr_word[5:0]};
  wire logic r2 = instr_word[7:6] == 2'h3;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  status_quiet_a: assert property (
    !ctl.status_we) else $error("status flag written");
  add_result_a: assert property (
    go && op == 8'hE8 && instr_word[7:6] == 2'h0 |->
    ctl.ptr_we && ctl.ptr_val == file_select_pointer0 + k)
    else $error("add result wrong");
  sub_result_a: assert property (
    go && op == 8'hE9 && instr_word[7:6] == 2'h0 |->
    ctl.ptr_we && ctl.ptr_val == file_select_pointer0 - k)
    else $error("subtract result wrong");
  link_return_a: assert property (
    go && (op == 8'hE8 || op == 8'hE9) && r2 |->
    ctl.ptr_sel == 2'h2 ##1 ctl.do_return && stall)
    else $error("return missing after pointer 2 update");
  push_store_a: assert property (
    go && op == 8'hEA |-> ctl.mem_we && ctl.mem_waddr == pointer_reg_2 &&
    ctl.mem_wdata == instr_word[7:0]) else $error("push store wrong");
  call_stall_a: assert property (
    go && instr_word == 16'h0014 |=> stall) else $error("call not stalled");
  idx_addr_a: assert property (
    idx_mode |-> idx_addr == pointer_reg_2 + {5'h00, std_file_operand[6:0]})
    else $error("indexed address wrong");
  idx_limit_a: assert property (
    std_access_bit || std_file_operand > 8'h5F |-> !idx_mode)
    else $error("indexed mode out of range");
  off_quiet_a: assert property (
    !ext_set_enable_cfg && !$past(ext_set_enable_cfg) |->
    !ext_hit && !idx_mode) else $error("extension active while off");
endmodule : eid_decoder_props
bind eid_decoder eid_decoder_props chk (.sys_clk(sys_clk), .rst(rst),
  .ext_set_enable_cfg(ext_set_enable_cfg), .instr_valid(instr_valid),
  .instr_word(instr_word), .file_select_pointer0(file_select_pointer0),
  .pointer_reg_2(pointer_reg_2), .std_access_bit(std_access_bit),
  .std_file_operand(std_file_operand), .ext_hit(ext_hit), .stall(stall),
  .idx_mode(idx_mode), .idx_addr(idx_addr), .ctl(ctl));
`default_nettype wire

// file: eid_decoder_test.sv
// self-checking bench for the extended instruction decoder
`default_nettype none
module eid_decoder_test import eid_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] w;
    logic [1:0] s;
    logic [11:0] v;
    logic m;
    logic r;
  } eid_row_s;
  // word, pointer select, new pointer, push store, return next cycle
  eid_row_s rows[8] = '{
    '{16'hE805, 2'h0, 12'h105, 1'b0, 1'b0},
    '{16'hE87F, 2'h1, 12'h23F, 1'b0, 1'b0},
    '{16'hE8A1, 2'h2, 12'h321, 1'b0, 1'b0},
    '{16'hE8C4, 2'h2, 12'h304, 1'b0, 1'b1},
    '{16'hE903, 2'h0, 12'h0FD, 1'b0, 1'b0},
    '{16'hE942, 2'h1, 12'h1FE, 1'b0, 1'b0},
    '{16'hE9FF, 2'h2, 12'h2C1, 1'b0, 1'b1},
    '{16'hEA5A, 2'h2, 12'h2FF, 1'b1, 1'b0}};
  logic sys_clk = 1'b0, rst = 1'b1, cfg = 1'b0, vld = 1'b0, acc = 1'b1;
  logic ext_hit, stall, idx_mode;
  logic [15:0] w = 16'h0000;
  logic [11:0] idx_addr;
  logic [7:0] rd = 8'hC3, f = 8'h00;
  eid_ctl_s ctl;
  eid_op_e seen;
  int err_total = 0, tests_run = 0, cyc = 0;
  eid_decoder dut (.sys_clk(sys_clk), .rst(rst), .ext_set_enable_cfg(cfg),
    .instr_valid(vld), .instr_word(w), .file_select_pointer0(12'h100),
    .file_select_pointer1(12'h200), .pointer_reg_2(12'h300),
    .working_reg(8'h11), .mem_rdata(rd), .std_access_bit(acc),
    .std_file_operand(f), .ext_hit(ext_hit), .stall(stall),
    .idx_mode(idx_mode), .idx_addr(idx_addr), .ctl(ctl), .op_seen(seen));
  always #12.5 sys_clk = ~sys_clk;
  task automatic complete_run;
    $display("err_total %0d tests_run %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 400) begin
      err_total++;
      complete_run();
    end
  end
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic nx;
    @(posedge sys_clk);
    #2;
  endtask : nx
  task automatic rs(input logic en);
    rst = 1'b1;
    cfg = en;
    // idle bus, so no stale word runs once the enable comes up
    {w, vld} = {16'h0000, 1'b0};
    repeat (10) nx();
    chk(ctl === '0 && stall === 1'b0, "reset outputs");
    rst = 1'b0;
    repeat (3) nx();
  endtask : rs
  task automatic mv(input logic [15:0] w1, w2, input logic [11:0] ra, wa);
    {w, vld, rd} = {w1, 1'b1, 8'hC3};
    #10 chk(ctl.mem_re === 1'b1 && ctl.mem_raddr === ra, "move read");
    nx();
    {w, rd} = {w2, 8'h3C};
    #10 chk(ctl.mem_we === 1'b1 && ctl.mem_waddr === wa &&
        ctl.mem_wdata === 8'hC3 && ext_hit === 1'b1, "move write");
    nx();
  endtask : mv
  task automatic ix(input logic a, input logic [7:0] fo, input logic e);
    {w, vld, acc, f} = {16'h0600, 1'b1, a, fo};
    #10 chk(idx_mode === e && (!e || idx_addr === 12'h300 + fo[6:0]), "idx");
    nx();
  endtask : ix
  initial begin
    rs(1'b0);
    {w, vld, acc} = {16'hE805, 1'b1, 1'b0};
    #10 chk(ext_hit === 1'b0 && ctl.ptr_we === 1'b0,
        "hit while off");
    chk(idx_mode === 1'b0, "indexed while off");
    rs(1'b1);
    foreach (rows[i]) begin
      {w, vld} = {rows[i].w, 1'b1};
      #10 chk(ext_hit === 1'b1 && ctl.ptr_we === 1'b1 &&
          ctl.ptr_sel === rows[i].s && ctl.ptr_val === rows[i].v &&
          ctl.status_we === 1'b0, "pointer update");
      chk(ctl.mem_we === rows[i].m && (!rows[i].m ||
          ctl.mem_waddr === 12'h300 && ctl.mem_wdata === rows[i].w[7:0]),
          "push");
      nx();
      {w, vld} = {16'h0000, 1'b0};
      #10 chk(stall === rows[i].r &&
          ctl.do_return === rows[i].r, "return");
      nx();
    end
    {w, vld} = {16'h0014, 1'b1};
    #10 chk(ctl.do_call_w === 1'b1 && ext_hit === 1'b1, "call");
    nx();
    vld = 1'b0;
    #10 chk(stall === 1'b1, "call stall");
    chk(seen === EID_CALL_REG, "op seen");
    nx();
    #10 chk(stall === 1'b0, "call done");
    nx();
    mv(16'hEB05, 16'hF123, 12'h305, 12'h123);
    mv(16'hEB85, 16'hFF8A, 12'h305, 12'h30A);
    ix(1'b0, 8'h5F, 1'b1);
    ix(1'b0, 8'h60, 1'b0);
    ix(1'b1, 8'h10, 1'b0);
    complete_run();
  end
endmodule : eid_decoder_test
`default_nettype wire

// file: eid_defs.svh
// constants for the extended instruction decoder
// How it works
// - extension off unless config enable bit set
// - eight extra instructions recognised
// - add literal to chosen pointer, one cycle
// - pointer 2 add-and-return takes two cycles
// - return follows pointer 2 update automatically
// - subtract literal from chosen pointer, one cycle
// - pointer 2 subtract-and-return, two cycles
// - call to working register target, two cycles
// - indexed to absolute file move, two words
// - indexed to indexed move, two words
// - push literal at pointer 2, then decrement
// - indexed offset mode for standard instructions
// - indexed mode when access bit zero, f<=95
`ifndef EID_DEFS_SVH
`define EID_DEFS_SVH
`define EID_OP_ADDPTR 8'hE8
`define EID_OP_SUBPTR 8'hE9
`define EID_OP_PUSH 8'hEA
`define EID_OP_MOVS 8'hEB
`define EID_OP_SECOND 4'hF
`define EID_CALL_REG_WORD 16'h0014
`define EID_PTR2_SEL 2'h2
`define EID_RET_SEL 2'h3
`define EID_IDX_LIMIT 8'h5F
`endif

// file: eid_pkg.sv
// types for the extended instruction decoder
`default_nettype none
package eid_pkg;
  typedef enum logic [3:0] {
    EID_NONE, EID_ADDP, EID_ADDR2, EID_SUBP, EID_SUBR2, EID_CALL_REG,
    EID_MOVE_IF, EID_MOVE_II, EID_PUSH_LIT
  } eid_op_e;
  typedef enum logic [1:0] {EID_IDLE, EID_SECOND, EID_RETURN} eid_state_e;
  typedef struct packed {
    logic ptr_we;
    logic [1:0] ptr_sel;
    logic [11:0] ptr_val;
    logic mem_re;
    logic [11:0] mem_raddr;
    logic mem_we;
    logic [11:0] mem_waddr;
    logic [7:0] mem_wdata;
    logic do_return;
    logic do_call_w;
    logic status_we;
  } eid_ctl_s;
endpackage : eid_pkg
`default_nettype wire
